// File: pbs_pkg.sv
// Constants and types for the power button and standby input control block
package pbs_pkg;

	// ============================================================
	// Timing
	localparam int CLK_FREQ_KHZ      = 250000;
	localparam int MS_CYCLES         = CLK_FREQ_KHZ;
	localparam int RESTART_WAIT_NS   = 30000;
	localparam int RESTART_WAIT_CYC  = (RESTART_WAIT_NS * (CLK_FREQ_KHZ / 1000) + 999) / 1000;
	localparam logic [9:0]  DBNC_SHORT_MS = 10'd32;
	localparam logic [9:0]  DBNC_MID_MS   = 10'd125;
	localparam logic [9:0]  DBNC_LONG_MS  = 10'd750;
	localparam logic [13:0] HOLD_1S_MS    = 14'd1000;
	localparam logic [13:0] HOLD_2S_MS    = 14'd2000;
	localparam logic [13:0] HOLD_3S_MS    = 14'd3000;
	localparam logic [13:0] HOLD_4S_MS    = 14'd4000;
	localparam logic [13:0] HOLD_8S_MS    = 14'd8000;
	localparam logic [13:0] LONG_2S_MS    = 14'd2000;
	localparam logic [13:0] LONG_4S_MS    = 14'd4000;
	localparam logic [13:0] LONG_8S_MS    = 14'd8000;
	localparam logic [13:0] LONG_16S_MS   = 14'd16000;
	localparam logic [13:0] HOLD_CAP_MS   = 14'd16001;

	// ============================================================
	// Summary register bit positions
	localparam int SUM_EWARN   = 7;
	localparam int SUM_BUTTON  = 6;
	localparam int SUM_OV      = 5;
	localparam int SUM_UV      = 4;
	localparam int SUM_ILIM    = 3;
	localparam int SUM_MODE    = 2;
	localparam int SUM_STAT2   = 1;
	localparam int SUM_STAT1   = 0;

	// ============================================================
	// Reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET  = 8'hff;

	// ============================================================
	// Types
	typedef struct packed {
		logic       reset_en;
		logic [1:0] delay_sel;
		logic [1:0] dbnc_sel;
		logic       stby_inv;
	} pbs_cfg_t;

	typedef struct packed {
		logic rsvd;
		logic hold8;
		logic hold4;
		logic hold3;
		logic hold2;
		logic hold1;
		logic release_f;
		logic press;
	} pbs_btn_flags_t;

	typedef enum logic [2:0] {
		ST_OFF  = 3'b001,
		ST_ON   = 3'b010,
		ST_RST  = 3'b100
	} pbs_state_t;

endpackage

// File: pbs_debounce.sv
// Two-threshold debounce filter counting millisecond ticks
`timescale 1ns/10ps
`default_nettype none
module pbs_debounce (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// Timing
	input  wire logic       ms_tick,
	input  wire logic [9:0] fall_ms,
	input  wire logic [9:0] rise_ms,
	// Signal
	input  wire logic       raw_in,
	output logic            level_r,
	output logic            fall_evt,
	output logic            rise_evt
);
	logic [9:0] cnt_r;
	logic [9:0] target;
	logic       differ;
	logic       flip;

	assign differ = raw_in != level_r;
	// Stable high waits for a falling edge, stable low for a rising one
	assign target = level_r ? fall_ms : rise_ms;
	assign flip   = differ && ms_tick && (cnt_r >= target);
	assign fall_evt = flip && level_r;
	assign rise_evt = flip && !level_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= 10'h000;
		end else if (!differ || flip) begin
			cnt_r <= 10'h000;
		end else if (ms_tick && cnt_r != 10'h3ff) begin
			cnt_r <= cnt_r + 10'h001;
		end
	end

	// Released level assumed at reset, matching the external pull-up
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			level_r <= 1'b1;
		end else if (flip) begin
			level_r <= raw_in;
		end
	end
endmodule // pbs_debounce
`default_nettype wire

// File: pbs_top.sv
// Power button, hold timers, long press, standby and interrupt summary
`timescale 1ns/10ps
`default_nettype none
module pbs_top #(
	parameter int MS_CYC      = pbs_pkg::MS_CYCLES,
	parameter int RESTART_CYC = pbs_pkg::RESTART_WAIT_CYC
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// Pins
	input  wire logic             power_button_input,
	input  wire logic             low_power_request,
	// One-time-programmable straps
	input  wire logic             button_mode_select,
	input  wire logic [1:0]       otp_debounce_select,
	input  wire logic [1:0]       otp_delay_select,
	// Software writes
	input  wire logic             cfg_wr_en,
	input  wire pbs_pkg::pbs_cfg_t cfg_wdata,
	input  wire logic             mask_wr_en,
	input  wire logic [7:0]       mask_wdata,
	input  wire logic             flag_clr_en,
	input  wire logic [7:0]       flag_clr_data,
	// Pending unmasked latches of other groups
	input  wire logic [7:0]       other_pending,
	// Register readback
	output logic                  button_level_sense,
	output pbs_pkg::pbs_btn_flags_t button_flags,
	output pbs_pkg::pbs_cfg_t     cfg_readback,
	output logic [7:0]            mask_readback,
	output logic [7:0]            interrupt_summary,
	output logic                  interrupt_request_output_n,
	// Power control
	output logic                  system_on,
	output logic                  power_on_event,
	output logic                  turn_off_event,
	output logic                  power_down_request,
	output logic                  standby_active
);
	import pbs_pkg::*;

	pbs_cfg_t       cfg_r;
	logic           mode_r;
	logic           load_r;
	pbs_btn_flags_t flags_r;
	logic [7:0]     mask_r;
	logic [7:0]     flag_set;
	pbs_state_t     state_r;
	logic [17:0]    div_r;
	logic           ms_tick;
	logic [13:0]    hold_ms_r;
	logic [12:0]    wait_r;
	logic           deb_level;
	logic           deb_fall;
	logic           deb_rise;
	logic           long_hit;
	logic           wait_done;

	function automatic logic [9:0] fall_ms_of(input logic [1:0] sel);
		case (sel)
			2'b10:   fall_ms_of = DBNC_MID_MS;
			2'b11:   fall_ms_of = DBNC_LONG_MS;
			default: fall_ms_of = DBNC_SHORT_MS;
		endcase
	endfunction

	function automatic logic [13:0] long_ms_of(input logic [1:0] sel);
		case (sel)
			2'b00:   long_ms_of = LONG_2S_MS;
			2'b01:   long_ms_of = LONG_4S_MS;
			2'b10:   long_ms_of = LONG_8S_MS;
			default: long_ms_of = LONG_16S_MS;
		endcase
	endfunction

	// ============================================================
	// Millisecond divider
	assign ms_tick = div_r == 18'(MS_CYC - 1);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= 18'h00000;
		end else if (ms_tick) begin
			div_r <= 18'h00000;
		end else begin
			div_r <= div_r + 18'h00001;
		end
	end

	// ============================================================
	// Configuration, OTP defaults taken after reset release and after a reset cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_r <= 1'b1;
		end else begin
			load_r <= wait_done;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_r  <= '0;
			mode_r <= 1'b0;
		end else if (load_r) begin
			cfg_r.reset_en  <= 1'b0;
			cfg_r.delay_sel <= otp_delay_select;
			cfg_r.dbnc_sel  <= otp_debounce_select;
			cfg_r.stby_inv  <= 1'b0;
			mode_r          <= button_mode_select;
		end else if (cfg_wr_en) begin
			cfg_r <= cfg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= MASK_RESET;
		end else if (mask_wr_en) begin
			mask_r <= mask_wdata;
		end
	end

	// ============================================================
	// Debounce and level sense
	pbs_debounce u_deb (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.ms_tick  (ms_tick),
		.fall_ms  (fall_ms_of(cfg_r.dbnc_sel)),
		.rise_ms  (DBNC_SHORT_MS),
		.raw_in   (power_button_input),
		.level_r  (deb_level),
		.fall_evt (deb_fall),
		.rise_evt (deb_rise)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			button_level_sense <= 1'b1;
		end else begin
			button_level_sense <= power_button_input;
		end
	end

	// ============================================================
	// Hold timer, cleared whenever the debounced button is released
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_ms_r <= 14'h0000;
		end else if (deb_level) begin
			hold_ms_r <= 14'h0000;
		end else if (ms_tick && hold_ms_r != HOLD_CAP_MS) begin
			hold_ms_r <= hold_ms_r + 14'h0001;
		end
	end

	// Equality compare fires once per press; a held button saturates past all limits
	assign long_hit = !deb_level && ms_tick && (hold_ms_r == long_ms_of(cfg_r.delay_sel));

	// ============================================================
	// Power state
	assign wait_done = (state_r == ST_RST) && (wait_r == 13'(RESTART_CYC - 1));

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			wait_r <= 13'h0000;
		end else if (state_r != ST_RST || wait_done) begin
			wait_r <= 13'h0000;
		end else begin
			wait_r <= wait_r + 13'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_OFF;
		end else begin
			case (state_r)
				ST_OFF: begin
					// Strap mode is not valid until the load cycle has passed
					if (load_r) begin
						state_r <= ST_OFF;
					end else if (!mode_r && deb_level) begin
						state_r <= ST_ON;
					end else if (mode_r && deb_fall) begin
						state_r <= ST_ON;
					end
				end
				ST_ON: begin
					if (!mode_r && !deb_level) begin
						state_r <= ST_OFF;
					end else if (long_hit && cfg_r.reset_en) begin
						state_r <= ST_RST;
					end else if (long_hit) begin
						state_r <= ST_OFF;
					end
				end
				ST_RST: begin
					if (wait_done) begin
						state_r <= ST_ON;
					end
				end
				default: state_r <= ST_OFF;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			power_on_event     <= 1'b0;
			turn_off_event     <= 1'b0;
			power_down_request <= 1'b0;
		end else begin
			power_on_event <= (state_r == ST_OFF) && !load_r &&
				((!mode_r && deb_level) || (mode_r && deb_fall));
			turn_off_event <= (state_r == ST_ON) &&
				((!mode_r && !deb_level) || (long_hit && !cfg_r.reset_en));
			power_down_request <= (state_r == ST_ON) && (mode_r || deb_level) &&
				long_hit && cfg_r.reset_en;
		end
	end

	assign system_on = state_r == ST_ON;

	// ============================================================
	// Standby request
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			standby_active <= 1'b0;
		end else begin
			standby_active <= system_on && (low_power_request ^ cfg_r.stby_inv);
		end
	end

	// ============================================================
	// Button latches; a new event beats a clear in the same cycle
	always_comb begin
		flag_set    = 8'h00;
		flag_set[0] = deb_fall && (system_on || (state_r == ST_OFF && mode_r));
		flag_set[1] = deb_rise && system_on;
		flag_set[2] = !deb_level && ms_tick && hold_ms_r == HOLD_1S_MS;
		flag_set[3] = !deb_level && ms_tick && hold_ms_r == HOLD_2S_MS;
		flag_set[4] = !deb_level && ms_tick && hold_ms_r == HOLD_3S_MS;
		flag_set[5] = !deb_level && ms_tick && hold_ms_r == HOLD_4S_MS;
		flag_set[6] = !deb_level && ms_tick && hold_ms_r == HOLD_8S_MS;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_r <= pbs_btn_flags_t'(FLAGS_RESET);
		end else begin
			flags_r <= pbs_btn_flags_t'((flags_r & ~(flag_clr_en ? flag_clr_data : 8'h00)) |
				flag_set);
		end
	end

	assign button_flags  = flags_r;
	assign cfg_readback  = cfg_r;
	assign mask_readback = mask_r;

	// ============================================================
	// First-level summary
	always_comb begin
		interrupt_summary             = other_pending;
		interrupt_summary[SUM_BUTTON] = |(flags_r & ~mask_r);
	end

	assign interrupt_request_output_n = ~|interrupt_summary;

	// ============================================================
	// Checks
	property p_level_sense;
		@(posedge sys_clk) disable iff (!reset_n)
		1'b1 |=> button_level_sense == $past(power_button_input);
	endproperty
	a_level_sense: assert property (p_level_sense) else $error("level sense wrong");

	property p_flag_sticky;
		@(posedge sys_clk) disable iff (!reset_n)
		(flags_r.press && !(flag_clr_en && flag_clr_data[0])) |=> flags_r.press;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("press flag lost");

	property p_set_wins;
		@(posedge sys_clk) disable iff (!reset_n)
		(flag_set[1] && flag_clr_en && flag_clr_data[1]) |=> flags_r.release_f;
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("clear beat set");

	property p_press_on;
		@(posedge sys_clk) disable iff (!reset_n)
		(deb_fall && system_on) |=> flags_r.press;
	endproperty
	a_press_on: assert property (p_press_on) else $error("press flag missing");

	property p_standby;
		@(posedge sys_clk) disable iff (!reset_n)
		system_on ##1 system_on |-> standby_active == $past(low_power_request ^ cfg_r.stby_inv);
	endproperty
	a_standby: assert property (p_standby) else $error("standby mismatch");

	property p_long_reset;
		@(posedge sys_clk) disable iff (!reset_n)
		(system_on && long_hit && cfg_r.reset_en && mode_r) |=>
			(state_r == ST_RST) && power_down_request;
	endproperty
	a_long_reset: assert property (p_long_reset) else $error("no reset cycle");

	property p_long_off;
		@(posedge sys_clk) disable iff (!reset_n)
		(system_on && long_hit && !cfg_r.reset_en) |=> (state_r == ST_OFF) && turn_off_event;
	endproperty
	a_long_off: assert property (p_long_off) else $error("no turn off");

	property p_level_mode_off;
		@(posedge sys_clk) disable iff (!reset_n)
		(system_on && !mode_r && !deb_level) |=> !system_on;
	endproperty
	a_level_mode_off: assert property (p_level_mode_off) else $error("on while low");

	property p_hold_restart;
		@(posedge sys_clk) disable iff (!reset_n)
		deb_level |=> hold_ms_r == 14'h0000 || !$past(deb_level);
	endproperty
	a_hold_restart: assert property (p_hold_restart) else $error("hold not restarted");

	property p_summary_clear;
		@(posedge sys_clk) disable iff (!reset_n)
		((flags_r & ~mask_r) == 8'h00) |-> !interrupt_summary[SUM_BUTTON];
	endproperty
	a_summary_clear: assert property (p_summary_clear) else $error("summary stuck");

	property p_otp_load;
		@(posedge sys_clk) disable iff (!reset_n)
		load_r |=> cfg_r.dbnc_sel == $past(otp_debounce_select) &&
			cfg_r.delay_sel == $past(otp_delay_select);
	endproperty
	a_otp_load: assert property (p_otp_load) else $error("otp default not loaded");
endmodule // pbs_top
`default_nettype wire

// File: pbs_pin_model.sv
// Push-button and host standby pin model for the button block
`timescale 1ns/10ps
`default_nettype none
module pbs_pin_model (
	// Commands from the bench
	input  wire logic press,
	input  wire logic stby_req,
	// Pins
	output logic      button_pin,
	output logic      stby_pin
);
	// ============================================================
	// Pins
	// Open switch leaves the pull-up in charge of the line
	assign button_pin = press ? 1'b0 : 1'b1;
	assign stby_pin   = stby_req;
endmodule // pbs_pin_model
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the power button and standby block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pbs_pkg::*;
	logic           sys_clk = 1'b0;
	logic           reset_n = 1'b0;
	logic           press = 1'b0;
	logic           stby_req = 1'b0;
	logic           btn_pin;
	logic           stby_pin;
	logic           mode_sel = 1'b1;
	logic [1:0]     otp_dbnc = 2'h2;
	logic [1:0]     otp_dly = 2'h1;
	logic           cfg_wr_en = 1'b0;
	pbs_cfg_t       cfg_wdata = '0;
	logic           mask_wr_en = 1'b0;
	logic [7:0]     mask_wdata = 8'h00;
	logic           flag_clr_en = 1'b0;
	logic [7:0]     flag_clr_data = 8'h00;
	logic [7:0]     other_pending = 8'h00;
	logic           level_sense;
	pbs_btn_flags_t flags;
	pbs_cfg_t       cfg_rb;
	logic [7:0]     mask_rb;
	logic [7:0]     summary;
	logic           irq_n;
	logic           sys_on;
	logic           pwr_on_evt;
	logic           off_evt;
	logic           pd_req;
	logic           stby_act;
	int             n_mismatch = 0;
	int             checks_done = 0;
	int             n;

	always #2 sys_clk = ~sys_clk;

	pbs_pin_model pbs_pin_model_inst (.press(press), .stby_req(stby_req),
		.button_pin(btn_pin), .stby_pin(stby_pin));

	pbs_top #(.MS_CYC(4), .RESTART_CYC(3)) pbs_top_inst (
		.sys_clk(sys_clk), .reset_n(reset_n),
		.power_button_input(btn_pin), .low_power_request(stby_pin),
		.button_mode_select(mode_sel), .otp_debounce_select(otp_dbnc),
		.otp_delay_select(otp_dly), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata),
		.mask_wr_en(mask_wr_en), .mask_wdata(mask_wdata), .flag_clr_en(flag_clr_en),
		.flag_clr_data(flag_clr_data), .other_pending(other_pending),
		.button_level_sense(level_sense), .button_flags(flags), .cfg_readback(cfg_rb),
		.mask_readback(mask_rb), .interrupt_summary(summary),
		.interrupt_request_output_n(irq_n), .system_on(sys_on),
		.power_on_event(pwr_on_evt), .turn_off_event(off_evt),
		.power_down_request(pd_req), .standby_active(stby_act));

	// ============================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Sel 0 config, 1 mask, 2 flag clear; one-cycle strobe
	task automatic wr(input int sel, input logic [7:0] v);
		@(negedge sys_clk);
		cfg_wr_en = (sel == 0);
		mask_wr_en = (sel == 1);
		flag_clr_en = (sel == 2);
		cfg_wdata = v[5:0];
		mask_wdata = v;
		flag_clr_data = v;
		@(negedge sys_clk);
		cfg_wr_en = 1'b0;
		mask_wr_en = 1'b0;
		flag_clr_en = 1'b0;
	endtask

	task automatic do_reset();
		reset_n = 1'b0;
		repeat (8) @(negedge sys_clk);
		reset_n = 1'b1;
		repeat (2) @(negedge sys_clk);
	endtask

	// ============================================================
	// Scenarios
	task automatic s_reset_vals();
		chk(cfg_rb, 32'h0c);
		chk(cfg_rb[4:3], 32'h1);
		chk({mask_rb, flags, level_sense, sys_on}, 32'h3fc02);
	endtask

	// Press shorter than the falling filter must not wake the device
	task automatic s_glitch();
		press = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(level_sense, 0);
		repeat (100) @(negedge sys_clk);
		press = 1'b0;
		repeat (200) @(negedge sys_clk);
		chk(level_sense, 1);
		chk({sys_on, flags}, 0);
	endtask

	task automatic s_power_on();
		press = 1'b1;
		n = 0;
		while (pwr_on_evt !== 1'b1 && n < 600) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n >= 496 && n <= 515, 1);
		@(negedge sys_clk);
		chk({sys_on, flags}, 32'h101);
		wr(2, 8'h01);
		chk(flags, 0);
		press = 1'b0;
		n = 0;
		while (flags.release_f !== 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n >= 124 && n <= 140, 1);
	endtask

	task automatic s_summary();
		other_pending = 8'h81;
		@(negedge sys_clk);
		chk({summary, irq_n}, 32'h102);
		wr(1, 8'hfd);
		chk({summary, irq_n}, 32'h182);
		wr(2, 8'h02);
		chk(summary, 32'h81);
		other_pending = 8'h00;
		@(negedge sys_clk);
		chk(irq_n, 1);
	endtask

	task automatic s_standby();
		for (int i = 0; i < 4; i++) begin
			wr(0, {7'h06, i[1]});
			stby_req = i[0];
			repeat (2) @(negedge sys_clk);
			chk(stby_act, i[0] ^ i[1]);
		end
		// Invert is still set here, so a low pin asks for standby
		stby_req = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk(stby_act, 1);
		stby_req = 1'b1;
		repeat (2) @(negedge sys_clk);
		chk(stby_act, 0);
		stby_req = 1'b0;
	endtask

	// Long press with reset enabled, eight-second delay, short filter
	task automatic s_long_reset();
		wr(0, 8'h30);
		wr(2, 8'hff);
		press = 1'b1;
		n = 0;
		while (pd_req !== 1'b1 && n < 33000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n >= 32120 && n <= 32150, 1);
		chk(flags[5:0], 32'h3d);
		repeat (10) @(negedge sys_clk);
		chk({sys_on, cfg_rb}, 32'h4c);
		chk(flags[6], 1);
		press = 1'b0;
		repeat (200) @(negedge sys_clk);
	endtask

	task automatic s_turn_off();
		wr(0, 8'h04);
		wr(2, 8'hff);
		press = 1'b1;
		n = 0;
		while (off_evt !== 1'b1 && n < 9000) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n >= 8490 && n <= 8520, 1);
		@(negedge sys_clk);
		chk({sys_on, flags[6:2]}, 32'h03);
		press = 1'b0;
		repeat (200) @(negedge sys_clk);
	endtask

	// Level mode: pin high powers on, long low drops to off
	task automatic s_level_mode();
		mode_sel = 1'b0;
		otp_dbnc = 2'h3;
		do_reset();
		repeat (8) @(negedge sys_clk);
		chk(sys_on, 1);
		press = 1'b1;
		n = 0;
		while (sys_on !== 1'b0 && n < 3100) begin
			@(negedge sys_clk);
			n++;
		end
		chk(n >= 2996 && n <= 3015, 1);
		chk(sys_on, 0);
	endtask

	// ============================================================
	// Main sequence and watchdog
	initial begin
		do_reset();
		s_reset_vals();
		s_glitch();
		s_power_on();
		s_summary();
		s_standby();
		s_long_reset();
		s_turn_off();
		s_level_mode();
		test_done();
	end

	// Whole run is about 45k cycles
	initial begin
		#300000;
		n_mismatch++;
		test_done();
	end
endmodule // tb_top
`default_nettype wire
